// *** gtc_timer.sv ***
// Gated 16-bit timer/counter with clock and gate source selection
`timescale 1ns/1ps
module gtc_timer (
  input wire logic mclk, // 10 MHz system clock
  input wire logic rst, // Asynchronous reset, active high
  input gtc_pkg::gtc_ctrl_t ctrl, // Control and configuration bits
  input gtc_pkg::gtc_write_t wr, // Byte write strobes and data
  input wire logic ovf_clear, // Clear overflow flag pulse
  input wire logic ext_count_clock_pin, // External count clock
  input wire logic ext_gate_pin, // External gate input
  input wire logic comparator_one, // Comparator 1 output
  input wire logic comparator_two, // Comparator 2 output
  input wire logic companion_8bit_timer_ovf, // Companion timer rollover pulse
  input wire logic low_freq_internal_osc, // Low-frequency oscillator
  output logic [7:0] count_low_byte, // Live count low byte
  output logic [7:0] count_high_byte, // Live count high byte
  output logic overflow_flag, // Sticky overflow flag
  output logic gate_value // Current gate level after polarity
);
  // Count, flag and their next values
  logic [15:0] count;
  logic [15:0] next_count;
  logic next_overflow;

  // Clock dividers and the counter-mode arming flag
  logic [1:0] instr_div;
  logic [2:0] prescale_cnt;
  logic armed;
  logic next_armed;

  // Gate and clock source edges
  logic gate_pulse;
  logic pin_raw;
  logic pin_rise;
  logic pin_fall;
  logic osc_rise;
  logic async_prev;
  logic async_rise;
  logic async_fall;

  // Synchronised pin path: a rise reaches the counter three edges later
  gtc_edge_detect u_pin_sync (
    .mclk(mclk),
    .rst(rst),
    .sig_in(ext_count_clock_pin),
    .level(),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // Oscillator only needs its rising edge; level and fall stay open
  gtc_edge_detect u_osc_sync (
    .mclk(mclk),
    .rst(rst),
    .sig_in(low_freq_internal_osc),
    .level(),
    .rise(osc_rise),
    .fall()
  );

  // Companion pulse is registered so the gate mux sees a flop, not a decode
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      gate_pulse <= 1'b0;
    else
      gate_pulse <= companion_8bit_timer_ovf;
  end

  // Unsynchronised path: the live pin against last cycle's sample, so a
  // pulse shorter than one system clock period can be missed
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      async_prev <= 1'b0;
    else
      async_prev <= ext_count_clock_pin;
  end

  assign pin_raw = ext_count_clock_pin;
  assign async_rise = pin_raw & ~async_prev;
  assign async_fall = ~pin_raw & async_prev;

  // Gate source decode; exactly one select is high for any field value
  wire gsel_pin = (ctrl.gate_select == gtc_pkg::GS_PIN);
  wire gsel_ovf8 = (ctrl.gate_select == gtc_pkg::GS_OVF8);
  wire gsel_cmp1 = (ctrl.gate_select == gtc_pkg::GS_CMP1);
  wire gsel_cmp2 = (ctrl.gate_select == gtc_pkg::GS_CMP2);

  wire gate_pin_term = gsel_pin & ext_gate_pin;
  wire gate_ovf_term = gsel_ovf8 & gate_pulse;
  wire gate_cmp1_term = gsel_cmp1 & comparator_one;
  wire gate_cmp2_term = gsel_cmp2 & comparator_two;
  wire gate_src = gate_pin_term | gate_ovf_term | gate_cmp1_term | gate_cmp2_term;
  // Polarity is applied here so gate_value reads the level the counter obeys
  assign gate_value = gate_src ^ ctrl.gate_polarity;

  // With gate_enable low the gate level is ignored and the counter free-runs
  wire run = ctrl.run_enable & (~ctrl.gate_enable | gate_value);

  // Clock source decode; secondary_osc_enable is ignored on purpose
  wire sel_instr = (ctrl.clock_select == gtc_pkg::CS_INSTR);
  wire sel_sys = (ctrl.clock_select == gtc_pkg::CS_SYS);
  wire is_ext = (ctrl.clock_select == gtc_pkg::CS_EXT);
  wire sel_osc = (ctrl.clock_select == gtc_pkg::CS_LFOSC);
  wire ext_rise = ctrl.ext_sync_enable ? pin_rise : async_rise;
  wire ext_fall = ctrl.ext_sync_enable ? pin_fall : async_fall;
  wire instr_tick = (instr_div == gtc_pkg::INSTR_DIV_LAST);
  // System clock ticks every edge, four per instruction cycle, so a read
  // taken once per instruction only resolves the count to a few LSBs
  wire instr_src = sel_instr & instr_tick;
  wire sys_src = sel_sys;
  wire ext_src = is_ext & ext_rise & armed;
  wire osc_src = sel_osc & osc_rise;
  wire src_tick = instr_src | sys_src | ext_src | osc_src;

  // Prescaler divides source ticks by 1, 2, 4 or 8; the compare is at-or-above
  // so a ratio cut while running cannot strand the divider above its new limit
  wire [3:0] prescale_div = 4'h1 << ctrl.prescale;
  wire [3:0] prescale_last = prescale_div - 4'h1;
  wire prescale_done = ({1'b0, prescale_cnt} >= prescale_last);
  wire prescale_step = run & src_tick;
  wire count_tick = prescale_step & prescale_done;
  wire any_write = wr.write_low | wr.write_high;
  // Divider restarts on a write or stop, so the next count is a full ratio away
  wire prescale_clear = any_write | ~ctrl.run_enable;
  // Any of these needs a fresh falling edge before the next counted rise
  wire disarm = any_write | ~ctrl.run_enable | ~is_ext;
  wire [15:0] count_inc = count + 16'h0001;
  // Wrap comes from the tick itself, so writing all ones never flags
  wire wrap = count_tick & (count == 16'hFFFF);

  // A byte write overrides a tick in the same cycle for the byte it writes
  always_comb
  begin
    next_count = count;
    if (count_tick)
      next_count = count_inc;
    if (wr.write_low)
      next_count[7:0] = wr.data;
    if (wr.write_high)
      next_count[15:8] = wr.data;
  end

  // Arm on a falling edge; disarm on write, disable or non-external mode
  always_comb
  begin
    next_armed = armed;
    if (ext_fall)
      next_armed = 1'b1;
    if (disarm)
      next_armed = 1'b0;
  end

  // Free-running divide-by-four for the instruction clock; writes do not move it
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      instr_div <= gtc_pkg::INSTR_DIV_RESET;
    else
      instr_div <= instr_div + 2'h1;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      prescale_cnt <= gtc_pkg::PRESCALE_RESET;
    else if (prescale_clear)
      prescale_cnt <= gtc_pkg::PRESCALE_RESET;
    else if (prescale_step)
      prescale_cnt <= prescale_done ? gtc_pkg::PRESCALE_RESET : prescale_cnt + 3'h1;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      count <= gtc_pkg::COUNT_RESET;
    else
      count <= next_count;
  end

  // Disarmed after reset so the first rise after power-up is never counted
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      armed <= 1'b0;
    else
      armed <= next_armed;
  end

  // Set wins over a clear in the same cycle
  always_comb
  begin
    next_overflow = overflow_flag;
    if (ovf_clear)
      next_overflow = 1'b0;
    if (wrap)
      next_overflow = 1'b1;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      overflow_flag <= 1'b0;
    else
      overflow_flag <= next_overflow;
  end

  // Both bytes come straight from the count flops, so they always agree
  assign count_low_byte = count[7:0];
  assign count_high_byte = count[15:8];
endmodule

// *** gtc_pkg.sv ***
// Package with constants and carrier types of the gated timer/counter
package gtc_pkg;
  localparam logic [1:0] CS_INSTR = 2'h0;
  localparam logic [1:0] CS_SYS = 2'h1;
  localparam logic [1:0] CS_EXT = 2'h2;
  localparam logic [1:0] CS_LFOSC = 2'h3;
  localparam logic [1:0] GS_PIN = 2'h0;
  localparam logic [1:0] GS_OVF8 = 2'h1;
  localparam logic [1:0] GS_CMP1 = 2'h2;
  localparam logic [1:0] GS_CMP2 = 2'h3;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
  localparam logic [1:0] INSTR_DIV_RESET = 2'h0;
  localparam logic [2:0] PRESCALE_RESET = 3'h0;
  localparam int SYS_STEP = 4;

  typedef struct packed {
    logic run_enable;
    logic gate_enable;
    logic gate_polarity;
    logic [1:0] gate_select;
    logic [1:0] clock_select;
    logic [1:0] prescale;
    logic ext_sync_enable;
    logic secondary_osc_enable;
  } gtc_ctrl_t;

  typedef struct packed {
    logic write_low;
    logic write_high;
    logic [7:0] data;
  } gtc_write_t;
endpackage

// *** gtc_edge_detect.sv ***
// Three-stage sampler with rise and fall detection for one input
`timescale 1ns/1ps
module gtc_edge_detect (
  input wire logic mclk, // System clock
  input wire logic rst, // Asynchronous reset
  input wire logic sig_in, // Sampled input
  output logic level, // Sampled level
  output logic rise, // One-cycle rise pulse
  output logic fall // One-cycle fall pulse
);
  logic stage1;
  logic stage2;
  logic stage3;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end
    else
    begin
      stage1 <= sig_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  assign level = stage2;
  assign rise = stage2 & ~stage3;
  assign fall = ~stage2 & stage3;
endmodule

// *** gtc_monitor.sv ***
// Assertion checker for the gated timer/counter
`timescale 1ns/1ps
module gtc_monitor (
  input wire logic mclk, // Clock
  input wire logic rst, // Reset
  input gtc_pkg::gtc_ctrl_t ctrl, // Control
  input gtc_pkg::gtc_write_t wr, // Writes
  input wire logic ovf_clear, // Clear
  input wire logic [7:0] count_low_byte, // Low
  input wire logic [7:0] count_high_byte, // High
  input wire logic overflow_flag, // Flag
  input wire logic gate_value // Gate
);
  wire logic [15:0] cnt = {count_high_byte, count_low_byte};
  wire logic nw = !wr.write_low && !wr.write_high;
  wire logic on = ctrl.run_enable && nw && ctrl.prescale == 2'h0;
  wire logic sys = on && ctrl.clock_select == gtc_pkg::CS_SYS;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence s_instr;
    (on && !ctrl.gate_enable && ctrl.clock_select == gtc_pkg::CS_INSTR) [*4];
  endsequence
  a_off_holds: assert property (!ctrl.run_enable && nw |=> $stable(cnt))
    else $error("moved while off");
  a_sys_step: assert property (sys && !ctrl.gate_enable |=> cnt == $past(cnt) + 16'h1)
    else $error("bad sys step");
  a_instr_step: assert property (s_instr |=> cnt == $past(cnt, 4) + 16'h1)
    else $error("bad instr rate");
  a_low_write: assert property (wr.write_low |=> count_low_byte == $past(wr.data))
    else $error("low write lost");
  a_high_write: assert property (wr.write_high |=> count_high_byte == $past(wr.data))
    else $error("high write lost");
  a_gate_holds: assert property (sys && ctrl.gate_enable && !gate_value |=> $stable(cnt))
    else $error("moved while gated");
  a_ovf_sets: assert property ($past(cnt) == 16'hFFFF && $past(nw) && cnt == 16'h0
    |-> ##[0:1] overflow_flag) else $error("no overflow flag");
  a_ovf_clears: assert property (ovf_clear && cnt != 16'hFFFF && cnt != 16'h0
    |=> !overflow_flag) else $error("flag not cleared");
endmodule
bind gtc_timer gtc_monitor gtc_monitor_inst (.*);

// *** gtc_src_model.sv ***
// Model of the external count clock and gate pin sources
`timescale 1ns/1ps
module gtc_src_model (
  input wire logic mclk, // Clock
  input wire logic gate_req, // Wanted gate
  output logic ext_count_clock_pin = 1'b0, // Count clock
  output logic ext_gate_pin // Gate pin
);
  assign ext_gate_pin = gate_req;
  task automatic pulses(input int n);
    repeat (n)
    begin
      ext_count_clock_pin <= 1'b1;
      repeat (4) @(posedge mclk);
      ext_count_clock_pin <= 1'b0;
      repeat (4) @(posedge mclk);
    end
  endtask
endmodule

// *** tb_top.sv ***
// Bench for the gated timer/counter
`timescale 1ns/1ps
module tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ovf_clear = 1'b0;
  logic low_freq_internal_osc = 1'b0;
  logic [3:0] gs = 4'h0;
  gtc_pkg::gtc_ctrl_t ctrl = '0;
  gtc_pkg::gtc_write_t wr = '0;
  wire logic gate_req = gs[0];
  wire logic companion_8bit_timer_ovf = gs[1];
  wire logic comparator_one = gs[2];
  wire logic comparator_two = gs[3];
  wire logic ext_count_clock_pin;
  wire logic ext_gate_pin;
  wire logic [7:0] count_low_byte;
  wire logic [7:0] count_high_byte;
  wire logic overflow_flag;
  wire logic gate_value;
  wire logic [15:0] cnt = {count_high_byte, count_low_byte};
  logic [15:0] d;
  int err_count = 0;
  int checks_done = 0;
  always #50 mclk = ~mclk;
  always #800 low_freq_internal_osc = ~low_freq_internal_osc;
  gtc_src_model gtc_src_model_inst (.*);
  gtc_timer gtc_timer_inst (.*);
  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic setc(input logic [10:0] v);
    @(posedge mclk) ctrl <= v;
    repeat (3) @(posedge mclk);
  endtask
  task automatic wr16(input logic [15:0] v);
    @(posedge mclk) wr <= {2'h2, v[7:0]};
    @(posedge mclk) wr <= {2'h1, v[15:8]};
    @(posedge mclk) wr <= '0;
    @(posedge mclk);
  endtask
  task automatic span(input int n);
    logic [15:0] a;
    a = cnt;
    repeat (n) @(posedge mclk);
    d = cnt - a;
  endtask
  task automatic t_clk();
    chk(cnt === 16'h0 && overflow_flag === 1'b0, "reset state");
    wr16(16'hA55A);
    chk(cnt === 16'hA55A, "byte writes");
    span(8);
    chk(d === 16'h0, "counted while off");
    setc(11'h411);
    span(12);
    chk(d === 16'(3 * gtc_pkg::SYS_STEP), "system clock rate");
    setc(11'h404);
    span(80);
    chk(d === 16'hA, "instruction rate by two");
    setc(11'h40C);
    span(64);
    chk(d === 16'h2, "instruction rate by eight");
    setc(11'h400);
    span(40);
    chk(d === 16'hA, "instruction rate");
    setc(11'h430);
    span(160);
    chk(d === 16'hA, "oscillator rate");
    $display("clock test done");
  endtask
  task automatic t_ext();
    for (int s = 1; s >= 0; s--)
    begin
      setc({9'h108, s[0], 1'b0});
      wr16(16'h0);
      gtc_src_model_inst.pulses(4);
      repeat (6) @(posedge mclk);
      chk(cnt === 16'h3, "pin count");
    end
    $display("external test done");
  endtask
  task automatic t_gate();
    for (int g = 0; g < 4; g++)
    begin
      setc({3'h6, 2'(g), 6'h10});
      span(8);
      chk(d === 16'h0 && gate_value === 1'b0, "counted with gate low");
      @(posedge mclk) gs[g] <= 1'b1;
      @(posedge mclk) gs[1] <= 1'b0;
      span(7);
      chk(d === (g == 1 ? 16'h1 : 16'h7), "gate source");
      gs <= 4'h0;
    end
    setc(11'h710);
    span(8);
    chk(d === 16'h8 && gate_value === 1'b1, "inverted gate");
    $display("gate test done");
  endtask
  task automatic t_ovf();
    setc(11'h0);
    wr16(16'hFFFE);
    setc(11'h410);
    @(posedge mclk);
    chk(overflow_flag === 1'b1, "overflow not set");
    @(posedge mclk) ovf_clear <= 1'b1;
    @(posedge mclk) ovf_clear <= 1'b0;
    @(posedge mclk);
    chk(overflow_flag === 1'b0, "overflow not cleared");
    $display("overflow test done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_clk();
    t_ext();
    t_gate();
    t_ovf();
    stop_test();
  end
endmodule
